// >>> hw/cfe_consts.svh
// offsets, field positions, reset values and codes of the feature block
`ifndef CFE_CONSTS_SVH
`define CFE_CONSTS_SVH
// ==========================================================
// configuration space byte offsets
`define CFE_OFS_CMD_STAT    8'h04
`define CFE_OFS_BAR0        8'h10
`define CFE_OFS_CIS         8'h28
`define CFE_OFS_ROM         8'h30
`define CFE_OFS_CAP         8'h34
// ==========================================================
// feature enable word bit positions
`define CFE_EN_BAR_LSB      0
`define CFE_EN_ROM_PRESET   6
`define CFE_EN_ROM_DECODE   7
`define CFE_EN_CAP_CHAIN    8
`define CFE_EN_CIS          9
`define CFE_EN_IACK         10
`define CFE_EN_RESERVED     11
`define CFE_EN_ARBITER      12
// ==========================================================
// register fields and reset values
`define CFE_STAT_CAP_BIT    4
`define CFE_CMD_IO_BIT      0
`define CFE_CMD_MEM_BIT     1
`define CFE_CMD_MST_BIT     2
`define CFE_CMD_WR_MASK     16'h0007
`define CFE_ROM_EN_BIT      0
`define CFE_RST_WORD        32'h0000_0000
`define CFE_RST_CMD         16'h0000
// ==========================================================
// bus command codes
`define CFE_CMD_IACK        4'h0
`define CFE_CMD_IO_RD       4'h2
`define CFE_CMD_IO_WR       4'h3
`define CFE_CMD_MEM_RD      4'h6
`define CFE_CMD_MEM_WR      4'h7
`define CFE_CMD_MEM_RDM     4'hc
`define CFE_CMD_MEM_RDL     4'he
`define CFE_CMD_MEM_WRI     4'hf
`endif

// >>> hw/cfe_pkg.sv
// types shared by the configuration feature block
package cfe_pkg;
  // ==========================================================
  // one configuration access from the bus target engine
  typedef struct packed {
    logic        we;     // write when set, read otherwise
    logic [5:0]  dw;     // dword index, byte offset / 4
    logic [3:0]  be;     // byte enables, active high
    logic [31:0] wdata;  // write data
  } cfe_cfg_req_t;
  // one decoded bus transaction address phase
  typedef struct packed {
    logic [3:0]  cmd;    // bus command code
    logic [31:0] addr;   // low address dword
    logic [31:0] addr_hi; // upper address, zero for single cycle
  } cfe_txn_t;
  // ==========================================================
  // sequencer states, one-hot
  typedef enum logic [1:0] {
    CFE_ST_LOAD = 2'b01,
    CFE_ST_RUN  = 2'b10
  } cfe_state_t;
endpackage : cfe_pkg

// >>> hw/cfe_feature_cfg.sv
// configuration header feature logic steered by the enable word
// Summary of operation
// - master features act only in master variants
// - 64-bit BAR on pair 0/1 or 1/2
// - six BAR bits preload preset base addresses
// - bit 6 preloads preset ROM base
// - bit 7: ROM size from configured size value, from the preset value when bit 6 is set
// - bit 7 clear: ROM BAR reads zero
// - bit 8 sets capability flag and pointer
// - bit 9 clear: info pointer reads zero
// - bit 10 selects interrupt-acknowledge response
// - acknowledge handled as ordinary memory read
// - bit 12 does not change the request tri-state
// - preset ROM read back and hit compare
// - capability pointer is 8-bit constant
`timescale 1ns/100ps
`include "cfe_consts.svh"
module cfe_feature_cfg (
  input  wire logic                  mclk,
  input  wire logic                  sys_rst,
  input  wire logic                  clk_en,
  // build-time configuration, held stable
  input  wire logic [31:0]           enable_bits,
  input  wire logic                  master_capable,
  input  wire logic [31:0]           bar_preset_value [0:5],
  input  wire logic [31:0]           bar_write_mask [0:5],
  input  wire logic [31:0]           bar_attr_bits [0:5],
  input  wire logic                  bar64_enable,
  input  wire logic                  bar64_pair_sel,
  input  wire logic [31:0]           rom_bar_preset_value,
  input  wire logic [31:0]           rom_bar_size_value,
  input  wire logic [7:0]            capability_pointer_value,
  input  wire logic [31:0]           cardbus_info_pointer_value,
  // configuration access
  input  wire logic                  cfg_valid,
  input  wire cfe_pkg::cfe_cfg_req_t cfg_req,
  output logic                       cfg_ack,
  output logic [31:0]                cfg_rdata,
  // transaction address phase
  input  wire logic                  txn_valid,
  input  wire cfe_pkg::cfe_txn_t     txn,
  output logic                       txn_claim,
  output logic [5:0]                 txn_bar_hit,
  output logic                       txn_rom_hit,
  output logic                       loc_read_req,
  output logic                       loc_read_is_iack,
  // bus request and grant
  input  wire logic                  master_req_n,
  input  wire logic                  gnt_n,
  output logic                       req_n_o,
  output logic                       req_n_oe,
  output logic                       master_granted
);
  // ==========================================================
  // helper functions
  // merge write data into a word under byte enables and a mask
  function automatic logic [31:0] cfe_merge(
    input logic [31:0] old_w,
    input logic [31:0] new_w,
    input logic [3:0]  be,
    input logic [31:0] wmask
  );
    logic [31:0] sel;
    sel = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
    cfe_merge = (old_w & ~sel) | (new_w & sel);
  endfunction : cfe_merge

  // compare address against a base over the decoded bits only
  function automatic logic cfe_match(
    input logic [31:0] addr,
    input logic [31:0] base,
    input logic [31:0] dmask
  );
    cfe_match = ((addr ^ base) & dmask) == 32'h0000_0000;
  endfunction : cfe_match

  // ==========================================================
  // state
  cfe_pkg::cfe_state_t state_r;      // sequencer
  cfe_pkg::cfe_state_t state_nxt;
  logic [31:0]         feat_r;       // captured enable word
  logic [15:0]         cmd_r;        // command register
  logic [31:0]         bar_r [0:5];  // base address registers
  logic [31:0]         rom_r;        // expansion rom base
  logic                cfg_ack_r;
  logic [31:0]         cfg_rdata_r;
  logic                claim_r;
  logic [5:0]          bar_hit_r;
  logic                rom_hit_r;
  logic                loc_rd_r;
  logic                loc_iack_r;

  // ==========================================================
  // feature decode
  wire        run        = state_r == cfe_pkg::CFE_ST_RUN;
  wire        f_rom_pre  = feat_r[`CFE_EN_ROM_PRESET];
  wire        f_rom_dec  = feat_r[`CFE_EN_ROM_DECODE];
  wire        f_cap      = feat_r[`CFE_EN_CAP_CHAIN];
  wire        f_cis      = feat_r[`CFE_EN_CIS];
  wire        f_iack     = feat_r[`CFE_EN_IACK];
  // arbiter option only exists where there is a master
  wire        f_arb      = feat_r[`CFE_EN_ARBITER] & master_capable;
  // bit 11 is dropped at capture, so nothing below can react to it
  wire        io_en      = cmd_r[`CFE_CMD_IO_BIT];
  wire        mem_en     = cmd_r[`CFE_CMD_MEM_BIT];
  wire        cmd_wr_hit = cfg_valid & cfg_req.we & run;
  wire [7:0]  cfg_ofs    = {cfg_req.dw, 2'b00};

  // master enable is writable only in a master variant
  wire [15:0] cmd_wmask  = master_capable ? `CFE_CMD_WR_MASK :
                           (`CFE_CMD_WR_MASK &
                            ~(16'h0001 << `CFE_CMD_MST_BIT));

  // status word: capability flag follows bit 8
  wire [15:0] stat_w     = {11'h000, f_cap, 4'h0};

  // ==========================================================
  // command classes
  wire t_iack   = txn.cmd == `CFE_CMD_IACK;
  wire t_io     = (txn.cmd == `CFE_CMD_IO_RD) |
                  (txn.cmd == `CFE_CMD_IO_WR);
  wire t_mem_rd = (txn.cmd == `CFE_CMD_MEM_RD)  |
                  (txn.cmd == `CFE_CMD_MEM_RDM) |
                  (txn.cmd == `CFE_CMD_MEM_RDL);
  wire t_mem    = t_mem_rd | (txn.cmd == `CFE_CMD_MEM_WR) |
                  (txn.cmd == `CFE_CMD_MEM_WRI);

  // ==========================================================
  // 64-bit pair placement: only 0/1 or 1/2 are possible
  wire [2:0]  pair_lo = bar64_pair_sel ? 3'd1 : 3'd0;
  wire [2:0]  pair_hi = bar64_pair_sel ? 3'd2 : 3'd1;
  wire [31:0] hi_base = bar_r[pair_hi];
  wire [31:0] hi_mask = bar_write_mask[pair_hi];
  // upper half matches the upper address over its decoded bits
  wire        hi_ok   = cfe_match(txn.addr_hi, hi_base, hi_mask);
  wire        hi_zero = txn.addr_hi == 32'h0000_0000;

  // ==========================================================
  // base address registers, one per slot
  logic [31:0] bar_rd [0:5];  // read view of each slot
  logic [5:0]  bar_hit;       // combinational hit per slot
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_bar
      wire is_lo  = bar64_enable & (pair_lo == 3'(gi));
      wire is_hi  = bar64_enable & (pair_hi == 3'(gi));
      wire is_iob = bar_attr_bits[gi][0];
      wire wr_me  = cmd_wr_hit &
                    (cfg_ofs == (`CFE_OFS_BAR0 + 8'(4 * gi)));
      // read shows writable base bits over fixed attribute bits
      assign bar_rd[gi] = (bar_r[gi] & bar_write_mask[gi]) |
                          (bar_attr_bits[gi] & ~bar_write_mask[gi]);
      // upper half of a pair never claims on its own
      assign bar_hit[gi] = ~is_hi &
        (is_iob ? (t_io & io_en) : ((t_mem | t_iack) & mem_en)) &
        cfe_match(txn.addr, bar_r[gi], bar_write_mask[gi]) &
        (is_lo ? hi_ok : hi_zero);

      // preset base loaded when the slot bit is set
      always_ff @(posedge mclk) begin
        if (sys_rst) begin
          bar_r[gi] <= `CFE_RST_WORD;
        end else if (clk_en) begin
          if (state_r == cfe_pkg::CFE_ST_LOAD) begin
            bar_r[gi] <= enable_bits[`CFE_EN_BAR_LSB + gi] ?
                         bar_preset_value[gi] : `CFE_RST_WORD;
          end else if (wr_me) begin
            bar_r[gi] <= cfe_merge(bar_r[gi], cfg_req.wdata,
                                   cfg_req.be, bar_write_mask[gi]);
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // expansion rom decode
  // writable bits come from the size value, plus the enable bit
  wire [31:0] rom_dmask = rom_bar_size_value & 32'hffff_f800;
  wire [31:0] rom_wmask = rom_dmask |
                          (32'h0000_0001 << `CFE_ROM_EN_BIT);
  // preset mode fixes the base; the register is not writable
  wire [31:0] rom_base  = f_rom_pre ? rom_bar_preset_value : rom_r;
  wire [31:0] rom_pmask = rom_bar_preset_value & 32'hffff_f800;
  wire [31:0] rom_rd    = ~f_rom_dec ? `CFE_RST_WORD :
                          (f_rom_pre ? rom_bar_preset_value :
                           (rom_r & rom_wmask));
  wire        rom_on    = f_rom_dec & mem_en &
                          (f_rom_pre | rom_r[`CFE_ROM_EN_BIT]);
  wire        rom_hit   = rom_on & t_mem_rd & hi_zero &
                          cfe_match(txn.addr, rom_base,
                                    f_rom_pre ? rom_pmask : rom_dmask);
  wire        rom_wr    = cmd_wr_hit & (cfg_ofs == `CFE_OFS_ROM) &
                          f_rom_dec & ~f_rom_pre;

  // rom base register; preset applied once at load
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rom_r <= `CFE_RST_WORD;
    end else if (clk_en) begin
      if (state_r == cfe_pkg::CFE_ST_LOAD) begin
        rom_r <= enable_bits[`CFE_EN_ROM_PRESET] ?
                 rom_bar_preset_value : `CFE_RST_WORD;
      end else if (rom_wr) begin
        rom_r <= cfe_merge(rom_r, cfg_req.wdata, cfg_req.be, rom_wmask);
      end
    end
  end

  // ==========================================================
  // configuration read mux
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = `CFE_RST_WORD;
    for (int k = 0; k < 6; k++) begin
      if (cfg_ofs == (`CFE_OFS_BAR0 + 8'(4 * k))) begin
        rd_mux = bar_rd[k];
      end
    end
    case (cfg_ofs)
      `CFE_OFS_CMD_STAT: rd_mux = {stat_w, cmd_r};
      `CFE_OFS_ROM:      rd_mux = rom_rd;
      // zero unless the info pointer is enabled
      `CFE_OFS_CIS:      rd_mux = f_cis ? cardbus_info_pointer_value :
                                  `CFE_RST_WORD;
      // pointer byte only with the chain enabled
      `CFE_OFS_CAP:      rd_mux = {24'h00_0000,
                                   f_cap ? capability_pointer_value :
                                   8'h00};
      default:           ;
    endcase
  end

  // ==========================================================
  // sequencer: capture enable word after reset release
  always_comb begin
    case (state_r)
      cfe_pkg::CFE_ST_LOAD: state_nxt = cfe_pkg::CFE_ST_RUN;
      cfe_pkg::CFE_ST_RUN:  state_nxt = cfe_pkg::CFE_ST_RUN;
      default:              state_nxt = cfe_pkg::CFE_ST_LOAD;
    endcase
  end

  // straps are sampled in the load state, never under reset
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_r <= cfe_pkg::CFE_ST_LOAD;
      feat_r  <= `CFE_RST_WORD;
    end else if (clk_en) begin
      state_r <= state_nxt;
      if (state_r == cfe_pkg::CFE_ST_LOAD) begin
        feat_r <= enable_bits &
                  ~(32'h0000_0001 << `CFE_EN_RESERVED);
      end
    end
  end

  // command register writes, merged at full width then cut to 16
  wire [31:0] cmd_merged = cfe_merge({16'h0000, cmd_r}, cfg_req.wdata,
                                     cfg_req.be, {16'h0000, cmd_wmask});
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cmd_r <= `CFE_RST_CMD;
    end else if (clk_en && cmd_wr_hit &&
                 cfg_ofs == `CFE_OFS_CMD_STAT) begin
      cmd_r <= cmd_merged[15:0];
    end
  end

  // ==========================================================
  // config answer, one cycle after the request
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cfg_ack_r   <= 1'b0;
      cfg_rdata_r <= `CFE_RST_WORD;
    end else if (clk_en) begin
      cfg_ack_r <= cfg_valid & run;
      if (cfg_valid && run && !cfg_req.we) begin
        cfg_rdata_r <= rd_mux;
      end
    end
  end

  // ==========================================================
  // transaction claim; acknowledge is taken as a memory read
  wire iack_take = t_iack & f_iack;
  wire any_bar   = |bar_hit;
  wire take      = txn_valid & run &
                   (iack_take | (~t_iack & (any_bar | rom_hit)));

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      claim_r    <= 1'b0;
      bar_hit_r  <= 6'h00;
      rom_hit_r  <= 1'b0;
      loc_rd_r   <= 1'b0;
      loc_iack_r <= 1'b0;
    end else if (clk_en) begin
      claim_r    <= take;
      bar_hit_r  <= (take & ~t_iack) ? bar_hit : 6'h00;
      rom_hit_r  <= take & ~t_iack & rom_hit;
      // same local read strobe as a memory read
      loc_rd_r   <= take & (t_mem_rd | t_iack);
      // tells the local side to supply the vector
      loc_iack_r <= take & t_iack;
    end
  end

  // ==========================================================
  // bus request drive
  // with or without the arbiter option the pin floats until running;
  // bit 12 is only seen once running, so it changes nothing here
  wire req_drive = f_arb | (master_capable & run);
  assign req_n_o        = (master_capable & run) ? master_req_n : 1'b1;
  assign req_n_oe       = req_drive;
  // grant from internal arbiter logic or a pin, same input
  assign master_granted = master_capable & run & ~gnt_n;

  assign cfg_ack          = cfg_ack_r;
  assign cfg_rdata        = cfg_rdata_r;
  assign txn_claim        = claim_r;
  assign txn_bar_hit      = bar_hit_r;
  assign txn_rom_hit      = rom_hit_r;
  assign loc_read_req     = loc_rd_r;
  assign loc_read_is_iack = loc_iack_r;
endmodule : cfe_feature_cfg

// >>> sim/cfe_arb_model.sv
// behavioural on-chip arbiter facing the request and grant lines
`timescale 1ns/100ps
module cfe_arb_model #(
  parameter int LAT = 2  // grant delay in cycles, 0 answers promptly
) (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic req_n,
  output logic      gnt_n
);
  // ==========================================================
  // grant logic
  logic [3:0] wait_r;  // cycles the request has been pending, held once it reaches LAT
  // grant only after LAT cycles of steady request; drop at once on release
  always_ff @(posedge mclk) begin
    if (sys_rst || req_n) begin
      gnt_n  <= 1'b1;
      wait_r <= 4'h0;
    end else if (wait_r >= LAT[3:0]) begin  // grant from inside the chip
      gnt_n  <= 1'b0;
    end else begin
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule : cfe_arb_model

// >>> sim/cfe_feature_cfg_checker.sv
// concurrent assertions on the configuration feature block ports
`timescale 1ns/100ps
module cfe_feature_cfg_checker (
  input wire logic                  mclk,
  input wire logic                  sys_rst,
  input wire logic                  clk_en,
  input wire logic [31:0]           enable_bits,
  input wire logic                  master_capable,
  input wire logic [7:0]            capability_pointer_value,
  input wire logic                  cfg_valid,
  input wire cfe_pkg::cfe_cfg_req_t cfg_req,
  input wire logic                  cfg_ack,
  input wire logic [31:0]           cfg_rdata,
  input wire logic                  txn_valid,
  input wire cfe_pkg::cfe_txn_t     txn,
  input wire logic                  txn_claim,
  input wire logic                  loc_read_req,
  input wire logic                  loc_read_is_iack,
  input wire logic                  req_n_o,
  input wire logic                  req_n_oe,
  input wire logic                  master_granted
);
  // ==========================================================
  // helper logic
  logic loaded_r;  // load edge has passed, requests now taken
  logic rd_take;   // configuration read taken this edge
  logic ia_take;   // interrupt-acknowledge taken this edge
  assign rd_take = cfg_valid && clk_en && loaded_r && !cfg_req.we;
  assign ia_take = txn_valid && clk_en && loaded_r && txn.cmd == 4'h0;
  // a request on the load edge itself is refused, so start one late
  always_ff @(posedge mclk) begin
    if (sys_rst) loaded_r <= 1'b0;
    else if (clk_en) loaded_r <= 1'b1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // assertions
  a_ack_has_cause: assert property (cfg_ack |-> $past(cfg_valid))
    else $error("ack without request");
  a_iack_ignored: assert property (
    ia_take && !enable_bits[10] |=> !txn_claim)
    else $error("acknowledge claimed while disabled");
  a_iack_claimed: assert property (
    ia_take && enable_bits[10]
    |=> txn_claim && loc_read_req && loc_read_is_iack)
    else $error("acknowledge not passed on as read");
  a_iack_is_read: assert property (
    loc_read_is_iack |-> loc_read_req && txn_claim)
    else $error("acknowledge flag without read");
  a_cap_pointer: assert property (
    rd_take && cfg_req.dw == 6'h0d |=> cfg_ack && cfg_rdata ==
    (enable_bits[8] ? {24'h0, capability_pointer_value} : 32'h0))
    else $error("capability pointer read wrong");
  a_cap_flag: assert property (
    rd_take && cfg_req.dw == 6'h01
    |=> cfg_rdata[20] == enable_bits[8])
    else $error("capability status flag wrong");
  a_info_zero: assert property (
    rd_take && cfg_req.dw == 6'h0a && !enable_bits[9]
    |=> cfg_rdata == 32'h0)
    else $error("info pointer not zero");
  a_rom_zero: assert property (
    rd_take && cfg_req.dw == 6'h0c && enable_bits[7:6] == 2'b00
    |=> cfg_rdata == 32'h0)
    else $error("rom bar not zero");
  a_req_driven: assert property (
    master_capable && enable_bits[12] && loaded_r |-> req_n_oe)
    else $error("request tri-state present");
  a_target_only: assert property (
    !master_capable |-> req_n_o && !master_granted)
    else $error("master activity in target variant");
endmodule : cfe_feature_cfg_checker
bind cfe_feature_cfg cfe_feature_cfg_checker u_chk (.mclk, .sys_rst, .clk_en,
  .enable_bits, .master_capable, .capability_pointer_value, .cfg_valid,
  .cfg_req, .cfg_ack, .cfg_rdata, .txn_valid, .txn, .txn_claim, .loc_read_req,
  .loc_read_is_iack, .req_n_o, .req_n_oe, .master_granted);

// >>> sim/cfe_feature_cfg_bench.sv
// self-checking bench for the configuration feature block
`timescale 1ns/100ps
module cfe_feature_cfg_bench;
  // ==========================================================
  // stimulus and observed signals
  logic mclk, sys_rst, clk_en, master_capable, bar64_enable, bar64_pair_sel;
  logic [31:0] enable_bits, rom_bar_preset_value, rom_bar_size_value;
  logic [31:0] cardbus_info_pointer_value, cfg_rdata;
  logic [31:0] bar_preset_value [0:5], bar_write_mask [0:5];
  logic [31:0] bar_attr_bits [0:5];
  logic [7:0]  capability_pointer_value;
  logic [5:0]  txn_bar_hit;
  logic cfg_valid, cfg_ack, txn_valid, txn_claim, txn_rom_hit, loc_read_req;
  logic loc_read_is_iack, master_req_n, gnt_n, req_n_o, req_n_oe;
  logic master_granted, req_line;
  cfe_pkg::cfe_cfg_req_t cfg_req;  // configuration access
  cfe_pkg::cfe_txn_t     txn;      // address phase
  int n_mismatch = 0;
  int n_tests    = 0;
  // released request line floats up through its pull-up
  assign req_line = req_n_oe ? req_n_o : 1'b1;
  cfe_feature_cfg u_dut (.mclk, .sys_rst, .clk_en, .enable_bits,
    .master_capable, .bar_preset_value, .bar_write_mask, .bar_attr_bits,
    .bar64_enable, .bar64_pair_sel, .rom_bar_preset_value, .rom_bar_size_value,
    .capability_pointer_value, .cardbus_info_pointer_value, .cfg_valid,
    .cfg_req, .cfg_ack, .cfg_rdata, .txn_valid, .txn, .txn_claim, .txn_bar_hit,
    .txn_rom_hit, .loc_read_req, .loc_read_is_iack, .master_req_n, .gnt_n,
    .req_n_o, .req_n_oe, .master_granted);
  cfe_arb_model #(.LAT(3)) u_arb (.mclk, .sys_rst, .req_n(req_line), .gnt_n);
  // ==========================================================
  // clock, 4 ns period
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // ==========================================================
  // shared tasks
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t word %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t bit %b expected %b", $time, got, exp);
    end
  endtask : chk_bit
  // reset with a new feature word, then let the load edge pass
  task automatic do_reset(input logic [31:0] en, input logic mc);
    @(posedge mclk);
    sys_rst <= 1'b1;
    enable_bits <= en;
    master_capable <= mc;
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask : do_reset
  // one configuration access, answer checked 1 ns after the edge that takes it
  task automatic cfg_rw(input logic we, input logic [5:0] dw,
                        input logic [31:0] wd);
    @(posedge mclk);
    cfg_valid <= 1'b1;
    cfg_req <= '{we, dw, 4'hf, wd};
    @(posedge mclk);
    cfg_valid <= 1'b0;
    #1;
    chk_bit(cfg_ack, 1'b1);
  endtask : cfg_rw
  // one address phase, results settled when the task returns
  task automatic txn_go(input logic [3:0] cmd, input logic [31:0] a,
                        input logic [31:0] ah = 32'h0);
    @(posedge mclk);
    txn_valid <= 1'b1;
    txn <= '{cmd, a, ah};
    @(posedge mclk);
    txn_valid <= 1'b0;
    #1;
  endtask : txn_go
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  // ==========================================================
  // scenarios
  // every feature off: optional registers read zero, acknowledge ignored
  task automatic t_feat_off;
    do_reset(32'h0, 1'b1);
    cfg_rw(1'b0, 6'h0d, 32'h0);
    chk_word(cfg_rdata, 32'h0);
    cfg_rw(1'b0, 6'h01, 32'h0);
    chk_bit(cfg_rdata[20], 1'b0);
    cfg_rw(1'b0, 6'h0a, 32'h0);
    chk_word(cfg_rdata, 32'h0);
    cfg_rw(1'b1, 6'h0c, 32'hffff_ffff);
    cfg_rw(1'b0, 6'h0c, 32'h0);
    chk_word(cfg_rdata, 32'h0);
    txn_go(4'h0, 32'h0);
    chk_bit(txn_claim, 1'b0);
    $display("t_feat_off done");
  endtask : t_feat_off
  // every feature on except BAR presets for slots 1 to 5, reserved bit set too and ignored
  task automatic t_feat_on;
    do_reset(32'h0000_1fc1, 1'b1);
    cfg_rw(1'b0, 6'h0d, 32'h0);
    chk_word(cfg_rdata, 32'h0000_005c);
    cfg_rw(1'b0, 6'h01, 32'h0);
    chk_bit(cfg_rdata[20], 1'b1);
    cfg_rw(1'b0, 6'h0a, 32'h0);
    chk_word(cfg_rdata, 32'h0000_2a01);
    cfg_rw(1'b0, 6'h0c, 32'h0);
    chk_word(cfg_rdata, 32'hff00_0000);
    cfg_rw(1'b0, 6'h04, 32'h0);
    chk_word(cfg_rdata, 32'h1234_5000);
    cfg_rw(1'b0, 6'h05, 32'h0);
    chk_word(cfg_rdata, 32'h0);
    cfg_rw(1'b1, 6'h01, 32'h0000_0007);
    txn_go(4'h6, 32'h1234_5010);
    chk_word({26'h0, txn_bar_hit}, 32'h1);
    chk_bit(loc_read_is_iack, 1'b0);
    txn_go(4'h6, 32'hff00_0100);
    chk_bit(txn_rom_hit, 1'b1);
    txn_go(4'h0, 32'h0);
    chk_bit(txn_claim, 1'b1);
    chk_bit(loc_read_req, 1'b1);
    // the bench plays the local side, which must now supply the vector
    chk_bit(loc_read_is_iack, 1'b1);
    $display("t_feat_on done");
  endtask : t_feat_on
  // arbiter option: request driven once running, grant from inside
  task automatic t_arbiter;
    @(posedge mclk);
    master_req_n <= 1'b0;
    @(posedge mclk);
    #1;
    chk_bit(req_n_oe, 1'b1);
    chk_bit(req_n_o, 1'b0);
    for (int i = 0; i < 8 && master_granted !== 1'b1; i++) @(posedge mclk);
    #1;
    chk_bit(master_granted, 1'b1);
    @(posedge mclk);
    master_req_n <= 1'b1;
    $display("t_arbiter done");
  endtask : t_arbiter
  // target-only variant ignores the master options
  task automatic t_target_only;
    do_reset(32'h0000_1000, 1'b0);
    master_req_n <= 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    chk_bit(req_n_o, 1'b1);
    chk_bit(req_n_oe, 1'b0);
    chk_bit(master_granted, 1'b0);
    @(posedge mclk);
    master_req_n <= 1'b1;
    $display("t_target_only done");
  endtask : t_target_only
  // 64-bit pair on slots 1/2, then a rom bar sized by its value
  task automatic t_bar64;
    do_reset(32'h0000_0082, 1'b1);
    bar64_enable <= 1'b1;
    bar64_pair_sel <= 1'b1;
    cfg_rw(1'b1, 6'h01, 32'h0000_0007);
    cfg_rw(1'b1, 6'h06, 32'h0000_3000);
    txn_go(4'h6, 32'h1234_5010, 32'h0000_3000);
    chk_word({26'h0, txn_bar_hit}, 32'h2);
    // upper address off: the low half alone must not claim
    txn_go(4'h6, 32'h1234_5010);
    chk_bit(txn_claim, 1'b0);
    // the upper half never claims on its own
    txn_go(4'h6, 32'h0000_3000, 32'h0000_3000);
    chk_bit(txn_claim, 1'b0);
    cfg_rw(1'b1, 6'h0c, 32'hffff_ffff);
    cfg_rw(1'b0, 6'h0c, 32'h0);
    chk_word(cfg_rdata, 32'hff00_0001);
    $display("t_bar64 done");
  endtask : t_bar64
  // ==========================================================
  // main sequence and watchdog
  initial begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    enable_bits = 32'h0;
    master_capable = 1'b0;
    bar64_enable = 1'b0;
    bar64_pair_sel = 1'b0;
    for (int i = 0; i < 6; i++) begin
      bar_preset_value[i] = 32'h1234_5000;
      bar_write_mask[i] = 32'hffff_f000;
      bar_attr_bits[i] = 32'h0;
    end
    rom_bar_preset_value = 32'hff00_0000;
    rom_bar_size_value = 32'hff00_0000;
    capability_pointer_value = 8'h5c;
    cardbus_info_pointer_value = 32'h0000_2a01;
    cfg_valid = 1'b0;
    cfg_req = '0;
    txn_valid = 1'b0;
    txn = '0;
    master_req_n = 1'b1;
    t_feat_off();
    t_feat_on();
    t_arbiter();
    t_target_only();
    t_bar64();
    test_done();
  end
  // whole run takes about 110 cycles; cut a hang off well after that
  initial begin
    #20000;
    n_mismatch++;
    test_done();
  end
endmodule : cfe_feature_cfg_bench
